// ### rtl/rcs_pkg.sv
/*
 * Shared constants of the reader command sequencer: operation codes,
 * register indices, field positions, reset values, counts and state types.
 * Assumes both ends are compiled after this package.
 */
package rcs_pkg;
	// operation codes
	localparam logic [3:0] OP_IDLE       = 4'h0;
	localparam logic [3:0] OP_MEM        = 4'h1;
	localparam logic [3:0] OP_RANDOM     = 4'h2;
	localparam logic [3:0] OP_CHECKSUM   = 4'h3;
	localparam logic [3:0] OP_TRANSMIT   = 4'h4;
	localparam logic [3:0] OP_KEEP       = 4'h7;
	localparam logic [3:0] OP_RECEIVE    = 4'h8;
	localparam logic [3:0] OP_TRANSCEIVE = 4'hC;
	localparam logic [3:0] OP_RESERVED   = 4'hD;
	localparam logic [3:0] OP_AUTH       = 4'hE;
	localparam logic [3:0] OP_SOFT_RESET = 4'hF;

	// device register indices
	localparam int          REG_ADDR_W      = 6;
	localparam logic [5:0] REG_COMMAND     = 6'h01;
	localparam logic [5:0] REG_EVENTS      = 6'h02;
	localparam logic [5:0] REG_ERRORS      = 6'h03;
	localparam logic [5:0] REG_STATUS2     = 6'h04;
	localparam logic [5:0] REG_FIFO_DATA   = 6'h05;
	localparam logic [5:0] REG_FIFO_LEVEL  = 6'h06;
	localparam logic [5:0] REG_FRAMING     = 6'h07;
	localparam logic [5:0] REG_MODE        = 6'h08;
	localparam logic [5:0] REG_RX_MODE     = 6'h09;
	localparam logic [5:0] REG_CRC_LOW     = 6'h0A;
	localparam logic [5:0] REG_CRC_HIGH    = 6'h0B;
	localparam logic [5:0] REG_SELF_CHECK  = 6'h0C;
	localparam logic [5:0] REG_SERIAL_RATE = 6'h0D;
	localparam logic [5:0] REG_TEST_A      = 6'h3D;
	localparam logic [5:0] REG_TEST_B      = 6'h3E;
	localparam logic [5:0] REG_TEST_C      = 6'h3F;

	// field positions
	localparam int CMD_SLEEP_BIT    = 4;
	localparam int CMD_RECEIVER_OFF_BIT_BIT   = 5;
	localparam int EV_RX_BIT        = 0;
	localparam int EV_TX_BIT        = 1;
	localparam int EV_IDLE_BIT      = 2;
	localparam int EV_TIMER_BIT     = 3;
	localparam int ERR_PROTO_BIT    = 0;
	localparam int ERR_WRITE_BIT    = 1;
	localparam int STAT2_CIPHER_BIT = 3;
	localparam int FRAME_START_BIT  = 7;
	localparam int RXMODE_MULTI_BIT = 2;
	localparam int FIFO_FLUSH_BIT   = 7;

	// reset values
	localparam logic [7:0] TEST_A_RESET      = 8'h00;
	localparam logic [7:0] TEST_B_RESET      = 8'h03;
	localparam logic [7:0] TEST_C_RESET      = 8'h00;
	localparam logic [7:0] SERIAL_RATE_RESET = 8'h00;

	// counts
	localparam int MEM_BYTES      = 25;
	localparam int RANDOM_BYTES   = 10;
	localparam int AUTH_ARG_BYTES = 12;

	// host-local register
	localparam logic [6:0] HOST_STATUS_ADDR = 7'h40;

	typedef enum logic [3:0] {
		ST_IDLE, ST_MEM_IN, ST_MEM_OUT, ST_RANDOM, ST_CRC, ST_TEST, ST_TEST_LO, ST_TEST_HI,
		ST_TX, ST_RX, ST_TRX_WAIT, ST_TRX_TX, ST_TRX_RX, ST_AUTH_ARG, ST_AUTH_RUN
	} rcs_state_type;

	typedef enum logic [1:0] {HS_IDLE, HS_WAIT, HS_RESP} rcs_host_state_type;
endpackage : rcs_pkg

// ### rtl/rcs_link_if.sv
/*
 * Register link between the host end and the device end.
 * Assumes both ends run on the same core_clk; the bench joins them.
 */
`timescale 1ns/1ps
interface rcs_link_if;
	logic       regReq;
	logic       regWrite;
	logic [5:0] regAddr;
	logic [7:0] regWrData;
	logic [7:0] regRdData;
	logic       regAck;
	logic [3:0] activeCmd;

	modport device (input regReq, regWrite, regAddr, regWrData, output regRdData, regAck, activeCmd);
	modport host (output regReq, regWrite, regAddr, regWrData, input regRdData, regAck, activeCmd);
endinterface : rcs_link_if

// ### rtl/rcs_device_end.sv
/*
 * Device end: operation sequencer with its FIFO, internal buffer, checksum
 * unit, random source and register file, reached over the register link.
 * Assumes the RF side and the card-cipher engine are same-clock logic.
 */
`timescale 1ns/1ps
// Contract
// - host writes code, device runs it via FIFO
// - stream ops start at once; transceive awaits start-send
// - fixed-argument ops wait for all argument bytes
// - starting an operation never clears the FIFO; the code clears it one cycle after a 1111 soft reset start
// - new code written aborts running operation
// - 0000 idle cancels and ends; 1101 reserved
// - 0001 stores 25 bytes, then idle
// - empty FIFO at start reads buffer out
// - 0010 writes 10 random bytes into buffer
// - 0011 checksums FIFO bytes, never limited
// - preset loaded at start; only host stops it
// - self-check key turns 0011 into self test
// - 0100 sends FIFO, ends when empty
// - 0111 changes bits, keeps running operation
// - 1000 receives to frame end; multiple keeps going
// - 1100 send on start-send, then receive, repeat
// - host preloads twelve authentication bytes in order
// - authentication blocks FIFO, sets write error, masks flags
// - authentication success ends with cipher bit set
// - host uses timer flag for silent card
// - authentication failure: protocol error, cipher cleared
// - 1111 resets registers, keeps buffer, then ends
module rcs_device_end #(
	parameter int          FIFO_DEPTH    = 64,
	parameter logic [15:0] CRC_POLY      = 16'h1021,
	parameter logic [15:0] PRESET_0      = 16'h0000,
	parameter logic [15:0] PRESET_1      = 16'h5555,
	parameter logic [15:0] PRESET_2      = 16'hAAAA,
	parameter logic [15:0] PRESET_3      = 16'hFFFF,
	parameter logic [3:0]  SELF_TEST_KEY = 4'h9,
	parameter int          RAND_BASE     = 0,
	parameter logic [15:0] LFSR_SEED     = 16'hACE1
) (
	// clock and reset
	input  logic                core_clk,
	input  logic                rst_n,
	// register link
	rcs_link_if.device          link,
	// transmit byte stream
	output logic                txValid,
	output logic [7:0]          txData,
	input  logic                txReady,
	// receive byte stream
	output logic                rxEnable,
	input  logic                rxValid,
	input  logic [7:0]          rxData,
	input  logic                rxEnd,
	// timer
	input  logic                timerExpire,
	// card cipher engine
	output logic                authReq,
	output logic [95:0]         authArgs,
	input  logic                authOk,
	input  logic                authFail,
	// command side bits
	output logic                sleepRequest,
	output logic                receiverOff
);
	localparam int FIFO_AW = $clog2(FIFO_DEPTH);

	rcs_pkg::rcs_state_type state;
	logic [7:0]         fifoMem [FIFO_DEPTH];
	logic [7:0]         memBuf [rcs_pkg::MEM_BYTES];
	logic [FIFO_AW-1:0] wrPtr;
	logic [FIFO_AW-1:0] rdPtr;
	logic [FIFO_AW:0]   fifoCount;
	logic [4:0]         idx;
	logic [15:0]        crcReg;
	logic [15:0]        lfsr;
	logic [3:0]         evFlags;
	logic [1:0]         errFlags;
	logic               cipherOn;
	logic               start_send_bit;
	logic               softResetReg;
	logic [1:0]         presetSel;
	logic               multiRx;
	logic [3:0]         selfCheck;
	logic [7:0]         serialRate;
	logic               clearAll;
	logic               fifoEmpty;
	logic               fifoFull;
	logic [7:0]         fifoHead;
	logic               smPush;
	logic               smPop;
	logic [7:0]         smPushData;
	logic               done;
	logic               hostSel;
	logic               isFifoAcc;
	logic               blocked;
	logic               hostGo;
	logic               hostPush;
	logic               hostPop;
	logic               push;
	logic               pop;
	logic               flush;
	logic               startOp;
	logic [3:0]         newCode;
	logic               txEnd;
	logic [7:0]         readValue;
	logic [15:0]        presetVal;
	logic [3:0]         evSet;
	logic [3:0]         evClr;
	logic [1:0]         errSet;
	logic [1:0]         errClr;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
		end
		return r;
	endfunction : crc_step

	assign clearAll  = !rst_n || softResetReg;
	assign fifoEmpty = (fifoCount == '0);
	assign fifoFull  = (fifoCount == (FIFO_AW+1)'(FIFO_DEPTH));
	assign fifoHead  = fifoEmpty ? 8'h00 : fifoMem[rdPtr];
	assign blocked   = (state == rcs_pkg::ST_AUTH_ARG) || (state == rcs_pkg::ST_AUTH_RUN);
	assign txEnd     = fifoEmpty && (!txValid || txReady);

	always_comb begin
		smPush     = 1'b0;
		smPop      = 1'b0;
		smPushData = 8'h00;
		done       = 1'b0;
		case (state)
			rcs_pkg::ST_MEM_IN: begin
				smPop = !fifoEmpty;
				done  = smPop && (idx == 5'(rcs_pkg::MEM_BYTES - 1));
			end
			rcs_pkg::ST_MEM_OUT: begin
				smPush     = !fifoFull;
				smPushData = memBuf[idx];
				done       = smPush && (idx == 5'(rcs_pkg::MEM_BYTES - 1));
			end
			rcs_pkg::ST_RANDOM: done = (idx == 5'(rcs_pkg::RANDOM_BYTES - 1));
			rcs_pkg::ST_CRC: smPop = !fifoEmpty;
			rcs_pkg::ST_TEST_LO: begin
				smPush     = !fifoFull;
				smPushData = crcReg[7:0];
			end
			rcs_pkg::ST_TEST_HI: begin
				smPush     = !fifoFull;
				smPushData = crcReg[15:8];
				done       = smPush;
			end
			rcs_pkg::ST_TX: begin
				smPop = !fifoEmpty && (!txValid || txReady);
				done  = txEnd;
			end
			rcs_pkg::ST_TRX_TX: smPop = !fifoEmpty && (!txValid || txReady);
			rcs_pkg::ST_RX, rcs_pkg::ST_TRX_RX: begin
				// overflow bytes are dropped rather than stalling the receiver
				smPush     = rxValid && !fifoFull;
				smPushData = rxData;
				done       = (state == rcs_pkg::ST_RX) && rxEnd && !multiRx;
			end
			rcs_pkg::ST_AUTH_ARG: smPop = !fifoEmpty;
			rcs_pkg::ST_AUTH_RUN: done = authOk || authFail;
			default: done = 1'b0;
		endcase
	end

	// host FIFO access waits only while the state machine holds the same port
	assign hostSel   = link.regReq && !link.regAck;
	assign isFifoAcc = hostSel && (link.regAddr == rcs_pkg::REG_FIFO_DATA);
	assign hostGo    = hostSel && !(isFifoAcc && !blocked && (link.regWrite ? smPush : smPop));
	assign hostPush  = hostGo && isFifoAcc && link.regWrite && !blocked && !fifoFull;
	assign hostPop   = hostGo && isFifoAcc && !link.regWrite && !blocked && !fifoEmpty;
	assign push      = smPush || hostPush;
	assign pop       = smPop || hostPop;
	assign flush     = hostGo && link.regWrite && (link.regAddr == rcs_pkg::REG_FIFO_LEVEL)
		&& link.regWrData[rcs_pkg::FIFO_FLUSH_BIT];
	assign newCode   = link.regWrData[3:0];
	assign startOp   = hostGo && link.regWrite && (link.regAddr == rcs_pkg::REG_COMMAND)
		&& (newCode != rcs_pkg::OP_KEEP);

	always_ff @(posedge core_clk) begin
		if (clearAll) begin
			state          <= rcs_pkg::ST_IDLE;
			link.activeCmd <= rcs_pkg::OP_IDLE;
			idx            <= '0;
		end else if (startOp) begin
			link.activeCmd <= (newCode == rcs_pkg::OP_RESERVED) ? rcs_pkg::OP_IDLE : newCode;
			idx            <= '0;
			case (newCode)
				rcs_pkg::OP_MEM: state <= fifoEmpty ? rcs_pkg::ST_MEM_OUT : rcs_pkg::ST_MEM_IN;
				rcs_pkg::OP_RANDOM: state <= rcs_pkg::ST_RANDOM;
				rcs_pkg::OP_CHECKSUM: state <= (selfCheck == SELF_TEST_KEY) ? rcs_pkg::ST_TEST : rcs_pkg::ST_CRC;
				rcs_pkg::OP_TRANSMIT: state <= rcs_pkg::ST_TX;
				rcs_pkg::OP_RECEIVE: state <= rcs_pkg::ST_RX;
				rcs_pkg::OP_TRANSCEIVE: state <= rcs_pkg::ST_TRX_WAIT;
				rcs_pkg::OP_AUTH: state <= rcs_pkg::ST_AUTH_ARG;
				default: state <= rcs_pkg::ST_IDLE;
			endcase
		end else if (done) begin
			state          <= rcs_pkg::ST_IDLE;
			link.activeCmd <= rcs_pkg::OP_IDLE;
		end else begin
			case (state)
				rcs_pkg::ST_MEM_IN, rcs_pkg::ST_MEM_OUT, rcs_pkg::ST_AUTH_ARG: begin
					if (smPop || smPush) begin
						idx <= idx + 5'h01;
					end
					if (state == rcs_pkg::ST_AUTH_ARG && smPop && idx == 5'(rcs_pkg::AUTH_ARG_BYTES - 1)) begin
						state <= rcs_pkg::ST_AUTH_RUN;
					end
				end
				rcs_pkg::ST_RANDOM: idx <= idx + 5'h01;
				rcs_pkg::ST_TEST: begin
					idx <= idx + 5'h01;
					if (idx == 5'(rcs_pkg::MEM_BYTES - 1)) begin
						state <= rcs_pkg::ST_TEST_LO;
					end
				end
				rcs_pkg::ST_TEST_LO: if (smPush) state <= rcs_pkg::ST_TEST_HI;
				rcs_pkg::ST_TRX_WAIT: if (start_send_bit) state <= rcs_pkg::ST_TRX_TX;
				rcs_pkg::ST_TRX_TX: if (txEnd) state <= rcs_pkg::ST_TRX_RX;
				rcs_pkg::ST_TRX_RX: if (rxEnd && !multiRx) state <= rcs_pkg::ST_TRX_WAIT;
				default: state <= state;
			endcase
		end
	end

	// FIFO; only flush or reset empties it, never an operation start
	always_ff @(posedge core_clk) begin
		if (clearAll || flush) begin
			wrPtr     <= '0;
			rdPtr     <= '0;
			fifoCount <= '0;
		end else begin
			if (push) begin
				fifoMem[wrPtr] <= hostPush ? link.regWrData : smPushData;
				wrPtr          <= wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= rdPtr + 1'b1;
			end
			case ({push, pop})
				2'b10: fifoCount <= fifoCount + 1'b1;
				2'b01: fifoCount <= fifoCount - 1'b1;
				default: fifoCount <= fifoCount;
			endcase
		end
	end

	// buffer has no reset so it outlives both resets
	always_ff @(posedge core_clk) begin
		if (state == rcs_pkg::ST_MEM_IN && smPop) begin
			memBuf[idx] <= fifoHead;
		end else if (state == rcs_pkg::ST_RANDOM) begin
			memBuf[5'(RAND_BASE) + idx] <= lfsr[7:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			lfsr <= LFSR_SEED;
		end else begin
			lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		end
	end

	always_comb begin
		case (presetSel)
			2'h0: presetVal = PRESET_0;
			2'h1: presetVal = PRESET_1;
			2'h2: presetVal = PRESET_2;
			default: presetVal = PRESET_3;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (clearAll) begin
			crcReg <= 16'h0000;
		end else if (startOp && newCode == rcs_pkg::OP_CHECKSUM) begin
			crcReg <= presetVal;
		end else if (state == rcs_pkg::ST_CRC && smPop) begin
			crcReg <= crc_step(crcReg, fifoHead);
		end else if (state == rcs_pkg::ST_TEST) begin
			crcReg <= crc_step(crcReg, memBuf[idx]);
		end
	end

	always_ff @(posedge core_clk) begin
		if (clearAll) begin
			txValid <= 1'b0;
			txData  <= 8'h00;
		end else if (smPop && (state == rcs_pkg::ST_TX || state == rcs_pkg::ST_TRX_TX)) begin
			txValid <= 1'b1;
			txData  <= fifoHead;
		end else if (txReady || startOp) begin
			txValid <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (clearAll) begin
			rxEnable <= 1'b0;
			authReq  <= 1'b0;
			authArgs <= '0;
		end else begin
			rxEnable <= (state == rcs_pkg::ST_RX || state == rcs_pkg::ST_TRX_RX) && !startOp && !done;
			authReq  <= (state == rcs_pkg::ST_AUTH_RUN) && !startOp && !done;
			if (state == rcs_pkg::ST_AUTH_ARG && smPop) begin
				authArgs <= {authArgs[87:0], fifoHead};
			end
		end
	end

	// flags: a hardware set in the clearing cycle wins
	always_comb begin
		evSet  = '0;
		evClr  = '0;
		errSet = '0;
		errClr = '0;
		if (!blocked) begin
			evSet[rcs_pkg::EV_RX_BIT] = rxEnd && (state == rcs_pkg::ST_RX || state == rcs_pkg::ST_TRX_RX);
			evSet[rcs_pkg::EV_TX_BIT] = txEnd && (state == rcs_pkg::ST_TX || state == rcs_pkg::ST_TRX_TX);
		end
		evSet[rcs_pkg::EV_IDLE_BIT]  = done;
		evSet[rcs_pkg::EV_TIMER_BIT] = timerExpire;
		errSet[rcs_pkg::ERR_WRITE_BIT] = (isFifoAcc && hostGo && blocked)
			|| (isFifoAcc && hostGo && link.regWrite && fifoFull);
		errSet[rcs_pkg::ERR_PROTO_BIT] = (state == rcs_pkg::ST_AUTH_RUN) && authFail;
		if (hostGo && link.regWrite && link.regAddr == rcs_pkg::REG_EVENTS) evClr = link.regWrData[3:0];
		if (hostGo && link.regWrite && link.regAddr == rcs_pkg::REG_ERRORS) errClr = link.regWrData[1:0];
	end

	always_ff @(posedge core_clk) begin
		if (clearAll) begin
			evFlags  <= '0;
			errFlags <= '0;
			cipherOn <= 1'b0;
		end else begin
			evFlags  <= (evFlags & ~evClr) | evSet;
			errFlags <= (errFlags & ~errClr) | errSet;
			if (state == rcs_pkg::ST_AUTH_RUN && authOk) begin
				cipherOn <= 1'b1;
			end else if (state == rcs_pkg::ST_AUTH_RUN && authFail) begin
				cipherOn <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (clearAll) begin
			start_send_bit    <= 1'b0;
			presetSel    <= 2'h0;
			multiRx      <= 1'b0;
			selfCheck    <= 4'h0;
			serialRate   <= rcs_pkg::SERIAL_RATE_RESET;
			sleepRequest <= 1'b0;
			receiverOff  <= 1'b0;
		end else begin
			if (state == rcs_pkg::ST_TRX_WAIT && start_send_bit) begin
				start_send_bit <= 1'b0;
			end
			if (hostGo && link.regWrite) begin
				case (link.regAddr)
					rcs_pkg::REG_COMMAND: begin
						sleepRequest <= link.regWrData[rcs_pkg::CMD_SLEEP_BIT];
						receiverOff  <= link.regWrData[rcs_pkg::CMD_RECEIVER_OFF_BIT_BIT];
					end
					rcs_pkg::REG_FRAMING: if (link.regWrData[rcs_pkg::FRAME_START_BIT]) start_send_bit <= 1'b1;
					rcs_pkg::REG_MODE: presetSel <= link.regWrData[1:0];
					rcs_pkg::REG_RX_MODE: multiRx <= link.regWrData[rcs_pkg::RXMODE_MULTI_BIT];
					rcs_pkg::REG_SELF_CHECK: selfCheck <= link.regWrData[3:0];
					rcs_pkg::REG_SERIAL_RATE: serialRate <= link.regWrData;
					default: serialRate <= serialRate;
				endcase
			end
		end
	end

	always_comb begin
		case (link.regAddr)
			rcs_pkg::REG_COMMAND: readValue = {2'b00, receiverOff, sleepRequest, link.activeCmd};
			rcs_pkg::REG_EVENTS: readValue = {4'h0, evFlags};
			rcs_pkg::REG_ERRORS: readValue = {6'h00, errFlags};
			rcs_pkg::REG_STATUS2: readValue = {4'h0, cipherOn, 3'h0};
			rcs_pkg::REG_FIFO_DATA: readValue = blocked ? 8'h00 : fifoHead;
			rcs_pkg::REG_FIFO_LEVEL: readValue = 8'(fifoCount);
			rcs_pkg::REG_FRAMING: readValue = {start_send_bit, 7'h00};
			rcs_pkg::REG_MODE: readValue = {6'h00, presetSel};
			rcs_pkg::REG_RX_MODE: readValue = {5'h00, multiRx, 2'h0};
			rcs_pkg::REG_CRC_LOW: readValue = crcReg[7:0];
			rcs_pkg::REG_CRC_HIGH: readValue = crcReg[15:8];
			rcs_pkg::REG_SELF_CHECK: readValue = {4'h0, selfCheck};
			rcs_pkg::REG_SERIAL_RATE: readValue = serialRate;
			rcs_pkg::REG_TEST_A: readValue = rcs_pkg::TEST_A_RESET;
			rcs_pkg::REG_TEST_B: readValue = rcs_pkg::TEST_B_RESET;
			rcs_pkg::REG_TEST_C: readValue = rcs_pkg::TEST_C_RESET;
			default: readValue = 8'h00;
		endcase
	end

	// soft reset pulses in the same cycle as its command's acknowledge
	always_ff @(posedge core_clk) begin
		if (clearAll) begin
			link.regAck    <= 1'b0;
			link.regRdData <= 8'h00;
			softResetReg   <= 1'b0;
		end else begin
			link.regAck  <= hostGo;
			softResetReg <= startOp && (newCode == rcs_pkg::OP_SOFT_RESET);
			if (hostGo) begin
				link.regRdData <= readValue;
			end
		end
	end
endmodule : rcs_device_end

// ### rtl/rcs_host_end.sv
/*
 * Host end: Avalon-MM slave with waitrequest that forwards word accesses
 * to the device registers over the link, plus one local status word.
 * Assumes a master that holds its request until waitrequest is low.
 */
`timescale 1ns/1ps
module rcs_host_end (
	// clock and reset
	input  logic        core_clk,
	input  logic        rst_n,
	// avalon slave
	input  logic [6:0]  avs_address,
	input  logic        avs_read,
	input  logic        avs_write,
	input  logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic        avs_waitrequest,
	// device link
	rcs_link_if.host    link
);
	rcs_pkg::rcs_host_state_type hostState;

	// waitrequest idles high; it drops only in the single answer cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			hostState       <= rcs_pkg::HS_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
			link.regReq     <= 1'b0;
			link.regWrite   <= 1'b0;
			link.regAddr    <= 6'h00;
			link.regWrData  <= 8'h00;
		end else begin
			case (hostState)
				rcs_pkg::HS_IDLE: begin
					if (avs_read || avs_write) begin
						if (avs_address[6]) begin
							avs_readdata    <= (avs_address == rcs_pkg::HOST_STATUS_ADDR)
								? {28'h000_0000, link.activeCmd} : 32'h0000_0000;
							avs_waitrequest <= 1'b0;
							hostState       <= rcs_pkg::HS_RESP;
						end else begin
							link.regReq    <= 1'b1;
							link.regWrite  <= avs_write;
							link.regAddr   <= avs_address[5:0];
							link.regWrData <= avs_writedata[7:0];
							hostState      <= rcs_pkg::HS_WAIT;
						end
					end
				end
				rcs_pkg::HS_WAIT: begin
					if (link.regAck) begin
						link.regReq     <= 1'b0;
						avs_readdata    <= {24'h00_0000, link.regRdData};
						avs_waitrequest <= 1'b0;
						hostState       <= rcs_pkg::HS_RESP;
					end
				end
				rcs_pkg::HS_RESP: begin
					avs_waitrequest <= 1'b1;
					hostState       <= rcs_pkg::HS_IDLE;
				end
				default: hostState <= rcs_pkg::HS_IDLE;
			endcase
		end
	end
endmodule : rcs_host_end

// ### sim/rcs_asserts.sv
/* Link checker: concurrent checks on the register link between the two ends.
 * Assumes one core_clk domain and instantiation beside the link instance. */
`timescale 1ns/1ps
module rcs_asserts (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       rst_n,
	// register link
	input wire logic       regReq,
	input wire logic       regWrite,
	input wire logic [5:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic [7:0] regRdData,
	input wire logic       regAck,
	input wire logic [3:0] activeCmd
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// acked write of one code into the command register
	sequence cmdWr(logic [3:0] c);
		regAck && regWrite && regAddr == rcs_pkg::REG_COMMAND && regWrData[3:0] == c;
	endsequence
	ack_one_cycle_a: assert property (regAck |=> !regAck)
		else $error("link ack held too long");
	ack_needs_req_a: assert property (regAck |-> regReq && $past(regReq))
		else $error("link ack without request");
	req_answered_a: assert property ($rose(regReq) |-> ##[1:64] regAck)
		else $error("link request not answered");
	idle_cancels_a: assert property (cmdWr(rcs_pkg::OP_IDLE) |-> ##[1:2] activeCmd == rcs_pkg::OP_IDLE)
		else $error("idle code did not stop the operation");
	reserved_idle_a: assert property (cmdWr(rcs_pkg::OP_RESERVED) |-> ##[1:2] activeCmd == rcs_pkg::OP_IDLE)
		else $error("reserved code did not act as idle");
	crc_runs_a: assert property (cmdWr(rcs_pkg::OP_CHECKSUM) |-> ##2 (activeCmd == rcs_pkg::OP_CHECKSUM)[*2])
		else $error("checksum operation did not keep running");
	keep_op_a: assert property (cmdWr(rcs_pkg::OP_KEEP) ##0 activeCmd == rcs_pkg::OP_CHECKSUM
		|=> (activeCmd == rcs_pkg::OP_CHECKSUM)[*3]) else $error("keep code changed the operation");
	soft_reset_a: assert property (cmdWr(rcs_pkg::OP_SOFT_RESET) |-> ##[1:4] activeCmd == rcs_pkg::OP_IDLE)
		else $error("soft reset did not end by itself");
endmodule : rcs_asserts

// ### sim/testbench.sv
/* Bench: host end and device end joined by the link, driven over Avalon-MM.
 * Assumes rcs_pkg, the link interface, both ends and the checker compiled first. */
`timescale 1ns/1ps
module testbench;
	localparam logic [6:0] aCmd = 7'h01, aEvt = 7'h02, aErr = 7'h03, aSt2 = 7'h04, aFifo = 7'h05;
	localparam logic [6:0] aLvl = 7'h06, aFrm = 7'h07, aMode = 7'h08, aCrcL = 7'h0A, aCrcH = 7'h0B;
	localparam logic [6:0] aRate = 7'h0D, aStat = 7'h40;
	localparam logic [6:0] rsvAddr [4] = '{7'h3D, 7'h3E, 7'h3F, 7'h20};
	localparam logic [7:0] rsvVal [4] = '{8'h00, 8'h03, 8'h00, 8'h00};
	logic        core_clk = 1'b0, rst_n = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
	logic        avsWaitrequest, txValid, receiverOff, sleepRequest, rxEnable, authReq;
	logic        txReady = 1'b0, authOk = 1'b0, authFail = 1'b0, timerExpire = 1'b0;
	logic [95:0] authArgs;
	logic [6:0]  avsAddress = 7'h00;
	logic [31:0] avsWritedata = 32'h0, avsReaddata;
	logic [7:0]  txData, q;
	logic [7:0]  memBuf [25];
	logic [7:0]  txSeen [$];
	logic [15:0] crc;
	int          numErrors = 0, nCompared = 0, n;

	always #2 core_clk = ~core_clk;
	// far side is ready every other cycle
	always @(posedge core_clk) txReady <= ~txReady;
	always @(posedge core_clk) if (txValid && txReady) txSeen.push_back(txData);

	rcs_link_if rcs_link_if_i ();
	rcs_host_end rcs_host_end_i (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avsAddress),
		.avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
		.avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .link(rcs_link_if_i));
	rcs_device_end rcs_device_end_i (
		.core_clk(core_clk), .rst_n(rst_n), .link(rcs_link_if_i), .txValid(txValid), .txData(txData),
		.txReady(txReady), .rxEnable(rxEnable), .rxValid(1'b0), .rxData(8'h00), .rxEnd(1'b0),
		.timerExpire(timerExpire), .authReq(authReq), .authArgs(authArgs), .authOk(authOk), .authFail(authFail),
		.sleepRequest(sleepRequest), .receiverOff(receiverOff));
	rcs_asserts rcs_asserts_i (.core_clk(core_clk), .rst_n(rst_n), .regReq(rcs_link_if_i.regReq),
		.regWrite(rcs_link_if_i.regWrite), .regAddr(rcs_link_if_i.regAddr), .regWrData(rcs_link_if_i.regWrData),
		.regRdData(rcs_link_if_i.regRdData), .regAck(rcs_link_if_i.regAck), .activeCmd(rcs_link_if_i.activeCmd));

	task automatic results;
		$display("compared %0d errors %0d", nCompared, numErrors);
		if (numErrors == 0 && nCompared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : results

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			numErrors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// one bus cycle; spare edge afterwards keeps back-to-back drives apart
	task automatic acc(input logic wr, input logic [6:0] a, input logic [7:0] d);
		int k;
		avsAddress <= a;
		avsWrite <= wr;
		avsRead <= ~wr;
		avsWritedata <= {24'h0, d};
		for (k = 0; k < 300 && (k == 0 || avsWaitrequest !== 1'b0); k++) @(posedge core_clk);
		if (avsWaitrequest !== 1'b0) begin
			numErrors++;
			results();
		end
		q = avsReaddata[7:0];
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
		@(posedge core_clk);
	endtask : acc

	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		check(q, e);
	endtask : rd

	task automatic waitIdle;
		for (n = 0; n < 200 && (n == 0 || q !== 8'h00); n++) acc(1'b0, aStat, 8'h00);
		check(q, 8'h00);
		if (q !== 8'h00) results();
	endtask : waitIdle

	task automatic memRead(input int lo);
		acc(1'b1, aCmd, {4'h0, rcs_pkg::OP_MEM});
		waitIdle();
		rd(aLvl, 8'h19);
		for (int i = 0; i < 25; i++) begin
			acc(1'b0, aFifo, 8'h00);
			if (i >= lo) check(q, memBuf[i]);
			else memBuf[i] = q;
		end
	endtask : memRead

	function automatic logic [15:0] crcStep(logic [15:0] c, logic [7:0] b);
		c = c ^ {b, 8'h00};
		repeat (8) c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
		return c;
	endfunction : crcStep

	initial begin
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		acc(1'b1, 7'h3E, 8'hFF);
		acc(1'b1, 7'h20, 8'h5A);
		foreach (rsvAddr[i]) rd(rsvAddr[i], rsvVal[i]);
		for (int i = 0; i < 25; i++) begin
			memBuf[i] = 8'h30 + 8'(i);
			acc(1'b1, aFifo, memBuf[i]);
		end
		acc(1'b1, aCmd, {4'h0, rcs_pkg::OP_MEM});
		waitIdle();
		rd(aLvl, 8'h00);
		memRead(0);
		acc(1'b1, aCmd, {4'h0, rcs_pkg::OP_RANDOM});
		waitIdle();
		memRead(10);
		for (int i = 0; i < 3; i++) acc(1'b1, aFifo, 8'hA0 + 8'(i));
		acc(1'b1, aCmd, {4'h0, rcs_pkg::OP_TRANSMIT});
		waitIdle();
		check(txSeen.size(), 3);
		foreach (txSeen[i]) check(txSeen[i], 8'hA0 + 8'(i));
		acc(1'b1, aMode, 8'h03);
		acc(1'b1, aCmd, {4'h0, rcs_pkg::OP_CHECKSUM});
		rd(aCrcH, 8'hFF);
		acc(1'b1, aFifo, 8'h31);
		crc = crcStep(16'hFFFF, 8'h31);
		acc(1'b1, aCmd, {4'h3, rcs_pkg::OP_KEEP});
		rd(aCrcL, crc[7:0]);
		rd(aCrcH, crc[15:8]);
		rd(aStat, {4'h0, rcs_pkg::OP_CHECKSUM});
		check({sleepRequest, receiverOff}, 2'b11);
		acc(1'b1, aCmd, {4'h0, rcs_pkg::OP_RESERVED});
		rd(aStat, 8'h00);
		txSeen.delete();
		acc(1'b1, aFifo, 8'h5C);
		acc(1'b1, aCmd, {4'h0, rcs_pkg::OP_TRANSCEIVE});
		rd(aLvl, 8'h01);
		acc(1'b1, aFrm, 8'h80);
		rd(aStat, {4'h0, rcs_pkg::OP_TRANSCEIVE});
		check(txSeen.size(), 1);
		check(rxEnable, 1'b1);
		acc(1'b1, aCmd, {4'h0, rcs_pkg::OP_IDLE});
		rd(aStat, 8'h00);
		for (int k = 0; k < 2; k++) begin
			acc(1'b1, aEvt, 8'hFF);
			for (int i = 0; i < 12; i++) acc(1'b1, aFifo, (i == 0) ? 8'h60 : 8'(i));
			acc(1'b1, aCmd, {4'h0, rcs_pkg::OP_AUTH});
			for (n = 0; n < 200 && authReq !== 1'b1; n++) @(posedge core_clk);
			check(authReq, 1'b1);
			check({authArgs[95:88], authArgs[7:0]}, 16'h600B);
			acc(1'b1, aFifo, 8'hEE);
			rd(aErr, 8'h02);
			authOk <= (k == 0);
			authFail <= (k == 1);
			@(posedge core_clk);
			authOk <= 1'b0;
			authFail <= 1'b0;
			waitIdle();
			rd(aSt2, (k == 0) ? 8'h08 : 8'h00);
			rd(aErr, (k == 0) ? 8'h02 : 8'h03);
			rd(aEvt, 8'h04);
			rd(aLvl, 8'h00);
		end
		acc(1'b1, 7'h0C, 8'h09);
		acc(1'b1, aCmd, {4'h0, rcs_pkg::OP_CHECKSUM});
		waitIdle();
		rd(aLvl, 8'h02);
		crc = 16'hFFFF;
		foreach (memBuf[i]) crc = crcStep(crc, memBuf[i]);
		rd(aFifo, crc[7:0]);
		rd(aFifo, crc[15:8]);
		timerExpire <= 1'b1;
		@(posedge core_clk);
		timerExpire <= 1'b0;
		rd(aEvt, 8'h0C);
		acc(1'b1, aRate, 8'h55);
		acc(1'b1, aCmd, {4'h0, rcs_pkg::OP_SOFT_RESET});
		waitIdle();
		rd(aRate, rcs_pkg::SERIAL_RATE_RESET);
		rd(aMode, 8'h00);
		rd(aErr, 8'h00);
		rd(aEvt, 8'h00);
		memRead(10);
		results();
	end
endmodule : testbench
